// file: ulc_pkg.sv
// package: register map, field positions, reset values and trigger tables of the line control block
// *****************************************************************************
// Functional notes
// *****************************************************************************
// Functional notes
// (R01) with enhanced features on, cts_n or rts_n rising sets status bit 5
// (R02) status bits 7:6 read zeros with queues off, ones with queues on
// (R03) queue control bit 0 enables queues; other bits taken only if bit 0 written one
// (R04) bit 1 with queues on pulses a receive queue pointer clear, then self-clears
// (R05) bit 2 with queues on pulses a transmit queue pointer clear, then self-clears
// (R06) bit 3 enables wake-up interrupt only with enhanced features on; resets off
// (R07) transmit request below trigger, or at empty if last reload never passed it
// (R08) receive request while receive level has reached the trigger
// (R09) receive and transmit always use the single most recently chosen table
// (R10) tables A, B, C give fixed levels indexed by the queue control codes
// (R11) table D ignores codes; trigger register writes go to rx or tx by select bit
// (R12) format bits 1:0 choose five, six, seven or eight data bits
// (R13) format bit 2 gives 1.5 stop bits at five bits, two otherwise
// (R14) format bit 3 adds parity on transmit and checks it on receive
// (R15) bit 4 low gives odd parity, high gives even, both directions
// (R16) bit 5 forces parity to one when bit 4 low, zero when high
// (R17) format bit 6 holds the serial output at space until cleared
// (R18) format bit 7 steers offsets 0 and 4 to the baud divisor registers
// (R19) handshake bit 0 drives dtr_n low when one, high when zero
// (R20) reads at the queue control offset return the interrupt status
package ulc_pkg;
	// *************************************************************************
	// register byte offsets
	// *************************************************************************
	localparam logic [7:0] OFS_DIV_LO = 8'h00;
	localparam logic [7:0] OFS_DIV_HI = 8'h04;
	localparam logic [7:0] OFS_QCTL   = 8'h08;
	localparam logic [7:0] OFS_CFMT   = 8'h0C;
	localparam logic [7:0] OFS_HSK    = 8'h10;
	localparam logic [7:0] OFS_EFC    = 8'h14;
	localparam logic [7:0] OFS_TTC    = 8'h18;
	localparam logic [7:0] OFS_PTRG   = 8'h1C;
	// *************************************************************************
	// field positions
	// *************************************************************************
	localparam int QC_EN      = 0;
	localparam int QC_RXCLR   = 1;
	localparam int QC_TXCLR   = 2;
	localparam int QC_WAKE    = 3;
	localparam int QC_TX_LO   = 4;
	localparam int QC_RX_LO   = 6;
	localparam int CF_STOP    = 2;
	localparam int CF_PAR_EN  = 3;
	localparam int CF_PAR_EV  = 4;
	localparam int CF_PAR_FRC = 5;
	localparam int CF_BREAK   = 6;
	localparam int CF_DIVACC  = 7;
	localparam int HS_DTR     = 0;
	localparam int EF_ENH     = 4;
	localparam int TT_TAB_LO  = 4;
	localparam int TT_SEL     = 7;
	localparam int IS_FLOW    = 5;
	// *************************************************************************
	// reset values and the table D code
	// *************************************************************************
	localparam logic [7:0] RST_REG8  = 8'h00;
	localparam logic [6:0] RST_PTRG  = 7'h01;
	localparam logic [1:0] TAB_D     = 2'h3;
	// *************************************************************************
	// trigger tables, indexed by the two-bit code
	// *************************************************************************
	localparam logic [3:0][6:0] TRG_RX_A = {7'h0E, 7'h08, 7'h04, 7'h01};
	localparam logic [3:0][6:0] TRG_TX_A = {7'h01, 7'h01, 7'h01, 7'h01};
	localparam logic [3:0][6:0] TRG_RX_B = {7'h1C, 7'h18, 7'h10, 7'h08};
	localparam logic [3:0][6:0] TRG_TX_B = {7'h1E, 7'h18, 7'h08, 7'h10};
	localparam logic [3:0][6:0] TRG_RX_C = {7'h3C, 7'h38, 7'h10, 7'h08};
	localparam logic [3:0][6:0] TRG_TX_C = {7'h38, 7'h20, 7'h10, 7'h08};
	// character format as seen by the shift registers
	typedef struct packed {
		logic [3:0] data_bits;
		logic       stop_half;
		logic       stop_two;
		logic       par_en;
		logic       par_even;
		logic       par_stick;
		logic       par_stick_val;
	} ulc_fmt_t;
endpackage

// file: ulc_top.sv
// line control, queue control and status view of the serial transceiver
`timescale 1ns/1ns
module ulc_top #(
	parameter int LVL_W = 7
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               pclken,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               cts_n,
	input  wire logic               rts_n,
	input  wire logic               flow_change_clr,
	input  wire logic               tx_serial,
	input  wire logic [7:0]         tx_char,
	input  wire logic [7:0]         rx_char,
	input  wire logic               rx_par_bit,
	input  wire logic               rx_char_valid,
	input  wire logic [LVL_W-1:0]   rx_level,
	input  wire logic [LVL_W-1:0]   tx_level,
	output logic                    tx_line,
	output logic                    dtr_n,
	output logic                    fifo_en,
	output logic                    rx_fifo_clr,
	output logic                    tx_fifo_clr,
	output logic                    wake_irq_en,
	output ulc_pkg::ulc_fmt_t       fmt,
	output logic                    divisor_access,
	output logic      [15:0]        divisor,
	output logic      [LVL_W-1:0]   rx_trig,
	output logic      [LVL_W-1:0]   tx_trig,
	output logic                    rx_irq_req,
	output logic                    tx_irq_req,
	output logic                    tx_par_bit,
	output logic                    rx_par_err,
	output logic                    flow_change
);
	// *************************************************************************
	// state
	// *************************************************************************
	logic [7:0]       cfmt_r;
	logic [7:0]       hsk_r;
	logic [7:0]       efc_r;
	logic [7:0]       ttc_r;
	logic [7:0]       div_lo_r;
	logic [7:0]       div_hi_r;
	logic [LVL_W-1:0] prg_rx_r;
	logic [LVL_W-1:0] prg_tx_r;
	logic [1:0]       rx_code_r;
	logic [1:0]       tx_code_r;
	logic             tx_filled_r;
	logic             cts_prev_r;
	logic             rts_prev_r;
	logic [31:0]      prdata_nxt;
	logic             pslverr_nxt;
	logic [7:0]       isr_view;
	logic [LVL_W-1:0] rx_trig_nxt;
	logic [LVL_W-1:0] tx_trig_nxt;
	logic             acc;
	logic             wr;
	logic             qwr;
	logic             enh;
	logic             flow_rise;

	assign acc = psel & penable & pready;
	assign wr  = acc & pwrite & pclken;
	assign qwr = wr & (paddr == ulc_pkg::OFS_QCTL) & pwdata[ulc_pkg::QC_EN];
	assign enh = efc_r[ulc_pkg::EF_ENH];
	assign flow_rise = enh & ((cts_n & ~cts_prev_r) | (rts_n & ~rts_prev_r));

	// *************************************************************************
	// helper functions
	// *************************************************************************
	function automatic logic [LVL_W-1:0] trig_pick(input logic [1:0] tab,
			input logic [1:0] code, input logic tx, input logic [LVL_W-1:0] prg);
		logic [6:0] v;
		v = 7'h00;
		case (tab)
			2'h0: v = tx ? ulc_pkg::TRG_TX_A[code] : ulc_pkg::TRG_RX_A[code];
			2'h1: v = tx ? ulc_pkg::TRG_TX_B[code] : ulc_pkg::TRG_RX_B[code];
			2'h2: v = tx ? ulc_pkg::TRG_TX_C[code] : ulc_pkg::TRG_RX_C[code];
			default: v = 7'h00;
		endcase
		trig_pick = (tab == ulc_pkg::TAB_D) ? prg : LVL_W'(v); // see (R10) see (R11)
	endfunction

	// parity over the active data bits, or the stuck value
	function automatic logic par_calc(input logic [7:0] ch, input logic [7:0] f);
		logic [7:0] m;
		m = 8'hFF >> (2'h3 - f[1:0]);
		if (f[ulc_pkg::CF_PAR_FRC])
			par_calc = ~f[ulc_pkg::CF_PAR_EV]; // see (R16)
		else
			par_calc = ^(ch & m) ^ ~f[ulc_pkg::CF_PAR_EV]; // see (R15)
	endfunction

	// *************************************************************************
	// apb slave
	// *************************************************************************
	// one wait state so read data and error come straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (pclken) begin
			pready  <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata  <= pwrite ? 32'h0000_0000 : prdata_nxt;
				pslverr <= pslverr_nxt;
			end
		end
	end

	always_comb begin
		isr_view = {{2{fifo_en}}, flow_change, 1'b0, 4'h1}; // see (R02)
		if (rx_irq_req)
			isr_view[3:0] = 4'h4;
		else if (tx_irq_req)
			isr_view[3:0] = 4'h2;
		else if (flow_change)
			isr_view[3:0] = 4'h0;
	end

	always_comb begin
		prdata_nxt  = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		case (paddr)
			ulc_pkg::OFS_DIV_LO: prdata_nxt[7:0] = cfmt_r[ulc_pkg::CF_DIVACC] ? div_lo_r : 8'h00;
			ulc_pkg::OFS_DIV_HI: prdata_nxt[7:0] = cfmt_r[ulc_pkg::CF_DIVACC] ? div_hi_r : 8'h00;
			ulc_pkg::OFS_QCTL:   prdata_nxt[7:0] = isr_view; // see (R20)
			ulc_pkg::OFS_CFMT:   prdata_nxt[7:0] = cfmt_r;
			ulc_pkg::OFS_HSK:    prdata_nxt[7:0] = hsk_r;
			ulc_pkg::OFS_EFC:    prdata_nxt[7:0] = efc_r;
			ulc_pkg::OFS_TTC:    prdata_nxt[7:0] = ttc_r;
			ulc_pkg::OFS_PTRG:   prdata_nxt[LVL_W-1:0] = ttc_r[ulc_pkg::TT_SEL] ? prg_tx_r : prg_rx_r;
			default:             pslverr_nxt = 1'b1;
		endcase
	end

	// *************************************************************************
	// plain read/write registers
	// *************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfmt_r   <= ulc_pkg::RST_REG8;
			hsk_r    <= ulc_pkg::RST_REG8;
			efc_r    <= ulc_pkg::RST_REG8;
			ttc_r    <= ulc_pkg::RST_REG8;
			div_lo_r <= ulc_pkg::RST_REG8;
			div_hi_r <= ulc_pkg::RST_REG8;
			prg_rx_r <= LVL_W'(ulc_pkg::RST_PTRG);
			prg_tx_r <= LVL_W'(ulc_pkg::RST_PTRG);
		end else if (wr) begin
			case (paddr)
				// data registers live elsewhere; only the divisor view is held here
				ulc_pkg::OFS_DIV_LO: if (cfmt_r[ulc_pkg::CF_DIVACC]) div_lo_r <= pwdata[7:0]; // see (R18)
				ulc_pkg::OFS_DIV_HI: if (cfmt_r[ulc_pkg::CF_DIVACC]) div_hi_r <= pwdata[7:0]; // see (R18)
				ulc_pkg::OFS_CFMT:   cfmt_r <= pwdata[7:0];
				ulc_pkg::OFS_HSK:    hsk_r  <= pwdata[7:0];
				ulc_pkg::OFS_EFC:    efc_r  <= pwdata[7:0];
				ulc_pkg::OFS_TTC:    ttc_r  <= pwdata[7:0];
				ulc_pkg::OFS_PTRG: begin
					if (ttc_r[ulc_pkg::TT_SEL])
						prg_tx_r <= pwdata[LVL_W-1:0]; // see (R11)
					else
						prg_rx_r <= pwdata[LVL_W-1:0]; // see (R11)
				end
				default: ;
			endcase
		end
	end

	// *************************************************************************
	// queue control
	// *************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_en     <= 1'b0;
			rx_fifo_clr <= 1'b0;
			tx_fifo_clr <= 1'b0;
			wake_irq_en <= 1'b0;
			rx_code_r   <= 2'h0;
			tx_code_r   <= 2'h0;
		end else if (pclken) begin
			rx_fifo_clr <= qwr & pwdata[ulc_pkg::QC_RXCLR]; // see (R04)
			tx_fifo_clr <= qwr & pwdata[ulc_pkg::QC_TXCLR]; // see (R05)
			if (wr & (paddr == ulc_pkg::OFS_QCTL))
				fifo_en <= pwdata[ulc_pkg::QC_EN]; // see (R03)
			if (qwr) begin
				rx_code_r <= pwdata[ulc_pkg::QC_RX_LO +: 2]; // see (R03)
				if (enh) begin
					wake_irq_en <= pwdata[ulc_pkg::QC_WAKE]; // see (R06)
					tx_code_r   <= pwdata[ulc_pkg::QC_TX_LO +: 2];
				end
			end
		end
	end

	// *************************************************************************
	// trigger levels and requests
	// *************************************************************************
	// one table field feeds both directions, so the last choice always wins
	assign rx_trig_nxt = trig_pick(ttc_r[ulc_pkg::TT_TAB_LO +: 2], rx_code_r, 1'b0,
		prg_rx_r); // see (R09)
	assign tx_trig_nxt = trig_pick(ttc_r[ulc_pkg::TT_TAB_LO +: 2], tx_code_r, 1'b1,
		prg_tx_r); // see (R09)

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_trig     <= '0;
			tx_trig     <= '0;
			rx_irq_req  <= 1'b0;
			tx_irq_req  <= 1'b0;
			tx_filled_r <= 1'b0;
		end else if (pclken) begin
			rx_trig    <= rx_trig_nxt;
			tx_trig    <= tx_trig_nxt;
			rx_irq_req <= fifo_en & (rx_level >= rx_trig_nxt); // see (R08)
			if (tx_level > tx_trig_nxt)
				tx_filled_r <= 1'b1;
			else if (tx_level == '0)
				tx_filled_r <= 1'b0;
			tx_irq_req <= fifo_en & (tx_filled_r ? (tx_level < tx_trig_nxt)
				: (tx_level == '0)); // see (R07)
		end
	end

	// *************************************************************************
	// flow control change flag
	// *************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// held at the idle level so leaving reset never looks like a rise
			cts_prev_r  <= 1'b1;
			rts_prev_r  <= 1'b1;
			flow_change <= 1'b0;
		end else if (pclken) begin
			cts_prev_r <= cts_n;
			rts_prev_r <= rts_n;
			// a rise in the clearing cycle is kept
			if (flow_rise)
				flow_change <= 1'b1; // see (R01)
			else if (flow_change_clr)
				flow_change <= 1'b0;
		end
	end

	// *************************************************************************
	// line format and pins
	// *************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt            <= '0;
			tx_line        <= 1'b1;
			dtr_n          <= 1'b1;
			divisor_access <= 1'b0;
			divisor        <= 16'h0000;
			tx_par_bit     <= 1'b0;
			rx_par_err     <= 1'b0;
		end else if (pclken) begin
			fmt.data_bits     <= 4'h5 + {2'h0, cfmt_r[1:0]}; // see (R12)
			fmt.stop_half     <= cfmt_r[ulc_pkg::CF_STOP] & (cfmt_r[1:0] == 2'h0); // see (R13)
			fmt.stop_two      <= cfmt_r[ulc_pkg::CF_STOP] & (cfmt_r[1:0] != 2'h0); // see (R13)
			fmt.par_en        <= cfmt_r[ulc_pkg::CF_PAR_EN]; // see (R14)
			fmt.par_even      <= cfmt_r[ulc_pkg::CF_PAR_EV]; // see (R15)
			fmt.par_stick     <= cfmt_r[ulc_pkg::CF_PAR_FRC]; // see (R16)
			fmt.par_stick_val <= ~cfmt_r[ulc_pkg::CF_PAR_EV]; // see (R16)
			tx_line        <= cfmt_r[ulc_pkg::CF_BREAK] ? 1'b0 : tx_serial; // see (R17)
			dtr_n          <= ~hsk_r[ulc_pkg::HS_DTR]; // see (R19)
			divisor_access <= cfmt_r[ulc_pkg::CF_DIVACC];
			divisor        <= {div_hi_r, div_lo_r};
			tx_par_bit     <= par_calc(tx_char, cfmt_r);
			rx_par_err     <= rx_char_valid & cfmt_r[ulc_pkg::CF_PAR_EN]
				& (rx_par_bit != par_calc(rx_char, cfmt_r)); // see (R14)
		end
	end

	// *************************************************************************
	// assertions
	// *************************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_qwrite;
		pclken && qwr;
	endsequence
	sequence s_one_pulse(sig);
		sig ##1 !sig;
	endsequence

	a_flow_set: assert property ( // see (R01)
		pclken && flow_rise |=> flow_change)
		else $error("flow change rise not flagged");
	a_fifo_status: assert property ( // see (R02)
		s_qwrite |=> fifo_en && isr_view[7:6] == 2'h3)
		else $error("queue status bits not set after enable");
	a_qctl_ignore: assert property ( // see (R03)
		wr && paddr == ulc_pkg::OFS_QCTL && !pwdata[0] |=> !fifo_en && $stable(rx_code_r)
		&& !rx_fifo_clr)
		else $error("queue control bits taken with enable low");
	a_rx_clear: assert property ( // see (R04)
		s_qwrite ##0 pwdata[ulc_pkg::QC_RXCLR] ##1 pclken |-> s_one_pulse(rx_fifo_clr))
		else $error("receive clear not a single pulse");
	a_tx_clear: assert property ( // see (R05)
		s_qwrite ##0 pwdata[ulc_pkg::QC_TXCLR] ##1 pclken |-> s_one_pulse(tx_fifo_clr))
		else $error("transmit clear not a single pulse");
	a_wake_gate: assert property ( // see (R06)
		s_qwrite ##0 !enh |=> $stable(wake_irq_en))
		else $error("wake enable changed without enhanced mode");
	a_tx_empty: assert property ( // see (R07)
		pclken && fifo_en && tx_level == '0 |=> tx_irq_req)
		else $error("empty transmit queue gave no request");
	a_rx_trig: assert property ( // see (R08)
		pclken && fifo_en && rx_level >= rx_trig_nxt |=> rx_irq_req)
		else $error("receive level at trigger gave no request");
	a_char_len: assert property ( // see (R12)
		pclken && cfmt_r[1:0] == 2'h3 |=> fmt.data_bits == 4'h8)
		else $error("eight-bit length not decoded");
	a_stop_len: assert property ( // see (R13)
		pclken && cfmt_r[ulc_pkg::CF_STOP] |=> fmt.stop_half != fmt.stop_two)
		else $error("long stop setting gave no single stop length");
	a_par_off: assert property ( // see (R14)
		pclken && !cfmt_r[ulc_pkg::CF_PAR_EN] |=> !rx_par_err)
		else $error("parity error flagged with parity off");
	a_break_hold: assert property ( // see (R17)
		pclken && cfmt_r[ulc_pkg::CF_BREAK] |=> !tx_line)
		else $error("break did not hold line at space");
	a_dtr_level: assert property ( // see (R19)
		pclken && $stable(hsk_r) |=> dtr_n == !$past(hsk_r[0]))
		else $error("dtr_n does not follow handshake bit");
	a_isr_read: assert property ( // see (R20)
		pclken && psel && penable && !pready && !pwrite && paddr == ulc_pkg::OFS_QCTL
		|=> prdata[7:6] == {2{$past(fifo_en)}})
		else $error("status read at queue offset wrong");
endmodule

// file: ulc_tb_pkg.sv
// verification helper: parity the line should carry for a character under a format code
package ulc_tb_pkg;
	// ****
	// parity
	// ****
	// only the bits inside the character length take part, the rest are don't-care
	function automatic logic par_calc(input logic [7:0] fc, input logic [7:0] ch);
		logic [7:0] m;
		m = ch & (8'hFF >> (2'h3 - fc[1:0]));
		if (fc[5])
			return ~fc[4];
		return fc[4] ? ^m : ~^m;
	endfunction
endpackage

// file: ulc_remote_model.sv
// remote transceiver model: hands received characters with their parity to the block
`timescale 1ns/1ns
module ulc_remote_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       send,
	input  wire logic       bad,
	input  wire logic [7:0] fmt_code,
	input  wire logic [7:0] ch,
	output logic      [7:0] rx_char,
	output logic            rx_par_bit,
	output logic            rx_char_valid
);
	// ****
	// character hand-over
	// ****
	// between characters the lines flip every cycle so a stale copy never looks valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_char       <= 8'h00;
			rx_par_bit    <= 1'b0;
			rx_char_valid <= 1'b0;
		end else if (send) begin
			rx_char       <= ch;
			rx_par_bit    <= ulc_tb_pkg::par_calc(fmt_code, ch) ^ bad;
			rx_char_valid <= 1'b1;
		end else begin
			rx_char       <= ~rx_char;
			rx_par_bit    <= ~rx_par_bit;
			rx_char_valid <= 1'b0;
		end
	end
endmodule

// file: uart_fifo_line_control_bench.sv
// self-checking bench of the line and queue control block
`timescale 1ns/1ns
module uart_fifo_line_control_bench;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              pclken = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata, rd, seed = 32'h4B;
	logic              pready, pslverr, er, cts_n = 1'b1, rts_n = 1'b1;
	logic              flow_change_clr = 1'b0, tx_serial = 1'b1, send = 1'b0, bad = 1'b0;
	logic [7:0]        tx_char = 8'h00, ch = 8'h00, fc = 8'h00, rx_char;
	logic              rx_par_bit, rx_char_valid, tx_line, dtr_n, fifo_en, rx_fifo_clr;
	logic              tx_fifo_clr, wake_irq_en, divisor_access, rx_irq_req, tx_irq_req;
	logic              tx_par_bit, rx_par_err, flow_change;
	logic [6:0]        rx_level = 7'h00, tx_level = 7'h00, rx_trig, tx_trig;
	logic [15:0]       divisor;
	ulc_pkg::ulc_fmt_t fmt;
	int                fail_count = 0, samples_checked = 0;
	int                m_fe = 0, m_enh = 0, m_wake = 0, m_tab = 0, m_rxc = 0, m_txc = 0;
	int                m_prx = 1, m_ptx = 1, m_flow = 0, filled = 0;
	int                rxt[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
	int                txt[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
	int                lv[$] = '{7, 20, 8, 10, 30, 17, 0, 0, 3, 5, 8, 16};

	ulc_top DUT (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cts_n(cts_n), .rts_n(rts_n),
		.flow_change_clr(flow_change_clr), .tx_serial(tx_serial), .tx_char(tx_char),
		.rx_char(rx_char), .rx_par_bit(rx_par_bit), .rx_char_valid(rx_char_valid),
		.rx_level(rx_level), .tx_level(tx_level), .tx_line(tx_line), .dtr_n(dtr_n),
		.fifo_en(fifo_en), .rx_fifo_clr(rx_fifo_clr), .tx_fifo_clr(tx_fifo_clr),
		.wake_irq_en(wake_irq_en), .fmt(fmt), .divisor_access(divisor_access),
		.divisor(divisor), .rx_trig(rx_trig), .tx_trig(tx_trig), .rx_irq_req(rx_irq_req),
		.tx_irq_req(tx_irq_req), .tx_par_bit(tx_par_bit), .rx_par_err(rx_par_err),
		.flow_change(flow_change));
	ulc_remote_model remote (.pclk(pclk), .presetn(presetn), .send(send), .bad(bad),
		.fmt_code(fc), .ch(ch), .rx_char(rx_char), .rx_par_bit(rx_par_bit),
		.rx_char_valid(rx_char_valid));

	always #5 pclk = ~pclk;
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int etr();
		return (m_tab == 3) ? m_prx : rxt[m_tab][m_rxc];
	endfunction
	function automatic int ett();
		return (m_tab == 3) ? m_ptx : txt[m_tab][m_txc];
	endfunction
	// expected status word: queue state on top, then the pending source
	function automatic logic [31:0] stat();
		logic rq;
		logic tq;
		rq = m_fe && rx_level >= etr();
		tq = m_fe && (filled ? tx_level < ett() : tx_level == 0);
		return {24'h0, m_fe[0], m_fe[0], m_flow[0], 1'b0,
			rq ? 4'h4 : (tq ? 4'h2 : (m_flow ? 4'h0 : 4'h1))};
	endfunction
	task automatic conclude();
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic settle();
		repeat (4) @(negedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(n < 50, 1, "no ready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(rd, e, "read");
		chk(er, 0, "slave error");
	endtask
	task automatic qw(input logic [7:0] d);
		int rc;
		int tc;
		rc = 0;
		tc = 0;
		wr(8'h08, d);
		repeat (4) begin
			@(negedge pclk);
			if (rx_fifo_clr === 1'b1) rc++;
			if (tx_fifo_clr === 1'b1) tc++;
		end
		m_fe = d[0];
		if (d[0] && m_enh) begin
			m_wake = d[3];
			m_txc = d[5:4];
		end
		if (d[0]) m_rxc = d[7:6];
		chk(rc, d[0] & d[1], "rx clear");
		chk(tc, d[0] & d[2], "tx clear");
		chk(fifo_en, d[0], "queue enable");
		chk(wake_irq_en, m_wake, "wake enable");
		chk(rx_trig, etr(), "rx trigger");
		chk(tx_trig, ett(), "tx trigger");
	endtask
	task automatic flow(input logic use_cts, input int e);
		@(posedge pclk);
		if (use_cts) cts_n <= 1'b0;
		else rts_n <= 1'b0;
		@(posedge pclk);
		cts_n <= 1'b1;
		rts_n <= 1'b1;
		settle();
		m_flow = e;
		chk(flow_change, e, "flow change");
		rdc(8'h08, stat());
		@(posedge pclk);
		flow_change_clr <= 1'b1;
		@(posedge pclk);
		flow_change_clr <= 1'b0;
		settle();
		m_flow = 0;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		logic p;
		int n;
		logic [7:0] d1;
		logic [7:0] d2;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		@(negedge pclk);
		chk(dtr_n, 1, "dtr reset");
		chk(fmt.data_bits, 5, "length reset");
		rdc(8'h08, 32'h01);
		rdc(8'h0C, 32'h00);
		apb(1'b0, 8'h20, 8'h00);
		chk(er, 1, "unmapped");
		qw(8'h39);
		rdc(8'h08, stat());
		flow(1'b0, 0);
		wr(8'h14, 8'h10);
		m_enh = 1;
		qw(8'h09);
		qw(8'h0E);
		rdc(8'h08, stat());
		for (int c = 3; c < 8; c++) qw(8'(c));
		flow(1'b1, 1);
		flow(1'b0, 1);
		for (int t = 0; t < 4; t++) begin
			wr(8'h18, 8'(t << 4));
			m_tab = t;
			if (t == 3) begin
				wr(8'h1C, 8'h14);
				m_prx = 20;
				wr(8'h18, 8'hB0);
				wr(8'h1C, 8'h28);
				m_ptx = 40;
				rdc(8'h1C, 32'h28);
			end
			for (int c = 0; c < 16; c++) qw({c[3:0], 4'h1});
		end
		wr(8'h18, 8'h10);
		m_tab = 1;
		qw(8'h01);
		for (int i = 0; i < lv.size(); i += 2) begin
			@(posedge pclk);
			rx_level <= 7'(lv[i]);
			tx_level <= 7'(lv[i + 1]);
			settle();
			if (lv[i + 1] > ett()) filled = 1;
			else if (lv[i + 1] == 0) filled = 0;
			chk(rx_irq_req, lv[i] >= etr(), "rx request");
			chk(tx_irq_req, filled ? lv[i + 1] < ett() : lv[i + 1] == 0, "tx request");
			rdc(8'h08, stat());
		end
		for (int i = 0; i < 64; i++) begin
			fc = 8'(i);
			wr(8'h0C, fc);
			@(posedge pclk);
			tx_char <= 8'(xs());
			settle();
			chk(fmt.data_bits, 5 + fc[1:0], "length");
			chk({fmt.stop_half, fmt.stop_two}, {fc[2] & ~|fc[1:0], fc[2] & |fc[1:0]}, "stop");
			chk(fmt.par_en, fc[3], "parity on");
			chk({fmt.par_even, fmt.par_stick, fmt.par_stick_val}, {fc[4], fc[5], ~fc[4]}, "par mode");
			if (fc[3]) chk(tx_par_bit, ulc_tb_pkg::par_calc(fc, tx_char), "tx parity");
			@(posedge pclk);
			ch <= 8'(xs());
			bad <= i[0] ^ i[3];
			send <= 1'b1;
			@(posedge pclk);
			send <= 1'b0;
			n = 0;
			repeat (4) begin
				@(negedge pclk);
				if (rx_par_err === 1'b1) n++;
			end
			chk(n, fc[3] & bad, "rx parity");
			rdc(8'h0C, fc);
		end
		for (int b = 1; b >= 0; b--) begin
			wr(8'h0C, b ? 8'h43 : 8'h03);
			wr(8'h10, 8'(b));
			settle();
			chk(dtr_n, !b, "dtr");
			rdc(8'h10, b);
			p = tx_serial;
			for (int k = 0; k < 8; k++) begin
				@(posedge pclk);
				d1 = 8'(xs());
				tx_serial <= d1[0];
				@(negedge pclk);
				chk(tx_line, b ? 1'b0 : p, "break");
				p = d1[0];
			end
		end
		wr(8'h00, 8'h5A);
		rdc(8'h00, 32'h0);
		wr(8'h0C, 8'h83);
		d1 = 8'(xs());
		d2 = 8'(xs());
		wr(8'h00, d1);
		wr(8'h04, d2);
		rdc(8'h00, d1);
		rdc(8'h04, d2);
		settle();
		chk(divisor_access, 1, "divisor access");
		chk(divisor, {d2, d1}, "divisor");
		wr(8'h0C, 8'h03);
		rdc(8'h00, 32'h0);
		settle();
		chk(divisor_access, 0, "divisor access");
		// clock enable low must freeze the line output
		@(posedge pclk);
		pclken <= 1'b0;
		tx_serial <= ~tx_serial;
		settle();
		chk(tx_line, !tx_serial, "frozen line");
		@(posedge pclk);
		pclken <= 1'b1;
		settle();
		chk(tx_line, tx_serial, "line");
		conclude();
	end
	initial begin
		#300000;
		fail_count++;
		conclude();
	end
endmodule
